/* design/status_pkg.sv */
// constants for the status byte and standard event logic
// assumes one clock domain; codes and commands come from the command parser
package status_pkg;

	// status byte bit positions
	localparam int STB_ERR_AVAIL = 2;
	localparam int STB_QUES_SUM = 3;
	localparam int STB_MSG_AVAIL = 4;
	localparam int STB_ESR_SUM = 5;
	localparam int STB_REQ_FLAG = 6;
	localparam int STB_OPER_SUM = 7;

	// standard event bit positions
	localparam int ESR_OPC = 0;
	localparam int ESR_RQC = 1;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int ESR_KEY = 6;
	localparam int ESR_PON = 7;

	// preset values
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic [7:0] ESE_RESET = 8'h00;
	localparam logic [7:0] ESR_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// error number class bounds
	localparam logic signed [15:0] QYE_LO = -16'sd499;
	localparam logic signed [15:0] QYE_HI = -16'sd400;
	localparam logic signed [15:0] DDE_LO = -16'sd399;
	localparam logic signed [15:0] DDE_HI = -16'sd300;
	localparam logic signed [15:0] DEV_LO = 16'sd1;
	localparam logic signed [15:0] DEV_HI = 16'sd32767;
	localparam logic signed [15:0] EXE_LO = -16'sd299;
	localparam logic signed [15:0] EXE_HI = -16'sd200;
	localparam logic signed [15:0] CME_LO = -16'sd199;
	localparam logic signed [15:0] CME_HI = -16'sd100;

	// common commands from the parser
	typedef enum logic [2:0]
	{
		CMD_SRE_WR = 3'h0,
		CMD_SRE_RD = 3'h1,
		CMD_ESE_WR = 3'h2,
		CMD_ESE_RD = 3'h3,
		CMD_ESR_RD = 3'h4,
		CMD_STB_RD = 3'h5,
		CMD_CLS = 3'h6,
		CMD_OPC = 3'h7
	} cmd_t;

endpackage

/* design/status_service_request.sv */
// status byte, standard event register and service request logic
// assumes the command parser and event sources share sys_clk; the poll
// strobe and the local key come from pins and are synchronised here
// the request line is open drain: only its enable ever toggles
// What this block does
// - request-service flag lives in bit 6 of the status byte
// - request starts on summary rise, enabled bit, none already pending
// - request pending from start until serial poll; no new one meanwhile
// - starting a request asserts the SRQ line and sets the flag
// - controller polls on SRQ; device returns its whole status byte
// - serial poll clears request-service flag only, other bits kept
// - byte query clears nothing; bit 6 carries master summary instead
// - master summary is 1 when any enabled reason is present
// - status bit 5 is the enabled standard event summary
// - status bit 7 is the operation event summary
// - queries return the register as binary bit weights
// - service request mask selects triggering bits; reads return last write
// - preset clears the service request mask
// - standard event mask selects bits for status bit 5; readable
// - preset clears the standard event mask
// - event bit 0 set when operations finish after operation-complete
// - event bit 1 always reads 0
// - bit 2 from query errors, bit 3 from device errors
// - bit 4 from execution errors, bit 5 from command errors
// - bit 6 on local key even in lockout; bit 7 after power cycle
// - event bits latch until read; read and preset clear them
// - clear-status empties error queue and clears event registers
`timescale 1ns/100ps
`default_nettype none

module status_service_request
(
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// instrument preset, same clock
	input wire logic preset,
	// common command from parser
	input wire logic cmd_valid,
	input wire status_pkg::cmd_t cmd_op,
	input wire logic [7:0] cmd_data,
	// query answer
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	// error reports
	input wire logic err_valid,
	input wire logic signed [15:0] err_code,
	// operation complete and summaries from other register sets
	input wire logic ops_idle,
	input wire logic oper_summary,
	input wire logic ques_summary,
	input wire logic err_avail,
	input wire logic msg_avail,
	// pins: local key and serial poll strobe
	input wire logic local_key,
	input wire logic poll_strobe,
	// serial poll answer
	output logic [7:0] poll_data,
	output logic poll_valid,
	// open-drain service request line
	output logic srq_o,
	output logic srq_oe,
	// clear-status pulse to error queue and other event registers
	output logic clear_status
);

	typedef struct packed
	{
		// registers seen by queries
		logic [7:0] sre;
		logic [7:0] ese;
		logic [7:0] esr;
		// request and operation tracking
		logic req_flag;
		logic opc_armed;
		logic boot;
		// previous summaries and pin synchronisers
		logic [7:0] prev_sum;
		logic key_meta;
		logic key_sync;
		logic key_prev;
		logic poll_meta;
		logic poll_sync;
		logic poll_prev;
		// output registers
		logic [7:0] rsp_data;
		logic rsp_valid;
		logic [7:0] poll_data;
		logic poll_valid;
		logic srq_o;
		logic srq_oe;
		logic clear_status;
	} state_t;

	state_t s_q;
	state_t s_d;

	// combinational views of the state
	logic [7:0] stb;
	logic [7:0] esr_set;
	logic summary_flag;
	logic start_req;
	logic poll_hit;
	logic key_hit;
	logic do_cmd;
	logic qye_hit;
	logic dde_hit;
	logic dev_hit;
	logic exe_hit;
	logic cme_hit;

	// elaboration checks on the package constants
	// every status byte position must fall inside the byte
	if (status_pkg::STB_ERR_AVAIL >= $bits(status_pkg::BYTE_ZERO)
		|| status_pkg::STB_QUES_SUM >= $bits(status_pkg::BYTE_ZERO)
		|| status_pkg::STB_MSG_AVAIL >= $bits(status_pkg::BYTE_ZERO)
		|| status_pkg::STB_ESR_SUM >= $bits(status_pkg::BYTE_ZERO)
		|| status_pkg::STB_REQ_FLAG >= $bits(status_pkg::BYTE_ZERO)
		|| status_pkg::STB_OPER_SUM >= $bits(status_pkg::BYTE_ZERO))
	begin : g_stb_range
		$error("status byte bit position out of range");
	end

	// every event position must fall inside the event byte
	if (status_pkg::ESR_OPC >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_RQC >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_QYE >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_DDE >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_EXE >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_CME >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_KEY >= $bits(status_pkg::ESR_RESET)
		|| status_pkg::ESR_PON >= $bits(status_pkg::ESR_RESET))
	begin : g_esr_range
		$error("event bit position out of range");
	end

	// each error class must be a real range, the negative classes in order and apart
	if (status_pkg::QYE_LO > status_pkg::QYE_HI
		|| status_pkg::DDE_LO > status_pkg::DDE_HI
		|| status_pkg::DEV_LO > status_pkg::DEV_HI
		|| status_pkg::EXE_LO > status_pkg::EXE_HI
		|| status_pkg::CME_LO > status_pkg::CME_HI
		|| status_pkg::QYE_HI >= status_pkg::DDE_LO
		|| status_pkg::DDE_HI >= status_pkg::EXE_LO
		|| status_pkg::EXE_HI >= status_pkg::CME_LO)
	begin : g_class_order
		$error("error class bounds out of order");
	end

	// the request flag needs a position of its own in the status byte
	if (status_pkg::STB_REQ_FLAG == status_pkg::STB_ESR_SUM
		|| status_pkg::STB_REQ_FLAG == status_pkg::STB_OPER_SUM
		|| status_pkg::STB_REQ_FLAG == status_pkg::STB_QUES_SUM
		|| status_pkg::STB_REQ_FLAG == status_pkg::STB_MSG_AVAIL
		|| status_pkg::STB_REQ_FLAG == status_pkg::STB_ERR_AVAIL)
	begin : g_flag_alone
		$error("request flag shares a status byte position");
	end

	// error number classes; a code outside every class sets nothing
	always_comb
	begin
		qye_hit = err_code >= status_pkg::QYE_LO
			&& err_code <= status_pkg::QYE_HI;
		dev_hit = err_code >= status_pkg::DEV_LO
			&& err_code <= status_pkg::DEV_HI;
		dde_hit = (err_code >= status_pkg::DDE_LO
			&& err_code <= status_pkg::DDE_HI) || dev_hit;
		exe_hit = err_code >= status_pkg::EXE_LO
			&& err_code <= status_pkg::EXE_HI;
		cme_hit = err_code >= status_pkg::CME_LO
			&& err_code <= status_pkg::CME_HI;
	end

	always_comb
	begin
		do_cmd = cmd_valid;
		// both pins idle low, so reset values give no false edge
		poll_hit = s_q.poll_sync && !s_q.poll_prev;
		key_hit = s_q.key_sync && !s_q.key_prev;

		// summary bits, bit 6 filled in per reader
		stb = status_pkg::BYTE_ZERO;
		stb[status_pkg::STB_ERR_AVAIL] = err_avail;
		stb[status_pkg::STB_QUES_SUM] = ques_summary;
		stb[status_pkg::STB_MSG_AVAIL] = msg_avail;
		stb[status_pkg::STB_ESR_SUM] = |(s_q.esr & s_q.ese);
		stb[status_pkg::STB_OPER_SUM] = oper_summary;

		// mask bit 6 has no source behind it, so it never counts
		summary_flag = |(stb & s_q.sre);

		// rising summary, enabled, and nothing pending; a rise while
		// pending is dropped, not queued, so the host re-reads summaries
		start_req = |(stb & ~s_q.prev_sum & s_q.sre)
			&& !s_q.req_flag;

		// event sources
		esr_set = status_pkg::BYTE_ZERO;
		esr_set[status_pkg::ESR_OPC] = s_q.opc_armed && ops_idle;
		if (err_valid)
		begin
			esr_set[status_pkg::ESR_QYE] = qye_hit;
			esr_set[status_pkg::ESR_DDE] = dde_hit;
			esr_set[status_pkg::ESR_EXE] = exe_hit;
			esr_set[status_pkg::ESR_CME] = cme_hit;
		end
		esr_set[status_pkg::ESR_KEY] = key_hit;
		// power-on reset leaves boot set for one cycle
		esr_set[status_pkg::ESR_PON] = s_q.boot;

		// hold by default, then layer the updates; later ones win
		s_d = s_q;
		s_d.boot = 1'b0;
		s_d.key_meta = local_key;
		s_d.key_sync = s_q.key_meta;
		s_d.key_prev = s_q.key_sync;
		s_d.poll_meta = poll_strobe;
		s_d.poll_sync = s_q.poll_meta;
		s_d.poll_prev = s_q.poll_sync;
		s_d.prev_sum = stb;
		s_d.rsp_valid = 1'b0;
		s_d.poll_valid = 1'b0;
		s_d.clear_status = 1'b0;
		if (esr_set[status_pkg::ESR_OPC])
		begin
			s_d.opc_armed = 1'b0;
		end

		// the poll edge is seen two edges after the pin rises, behind the
		// two synchroniser stages; the answer registers on the third edge
		// poll answer carries the flag as it stood before clearing
		if (poll_hit)
		begin
			s_d.poll_data = stb;
			s_d.poll_data[status_pkg::STB_REQ_FLAG] = s_q.req_flag;
			s_d.poll_valid = 1'b1;
			s_d.req_flag = 1'b0;
		end
		// a new request in the poll cycle wins over the clear
		if (start_req)
		begin
			s_d.req_flag = 1'b1;
		end

		// queries answer one cycle after the command edge; writes
		// give no answer at all
		if (do_cmd)
		begin
			unique case (cmd_op)
				status_pkg::CMD_SRE_WR:
				begin
					s_d.sre = cmd_data;
				end
				status_pkg::CMD_SRE_RD:
				begin
					s_d.rsp_data = s_q.sre;
					s_d.rsp_valid = 1'b1;
				end
				status_pkg::CMD_ESE_WR:
				begin
					s_d.ese = cmd_data;
				end
				status_pkg::CMD_ESE_RD:
				begin
					s_d.rsp_data = s_q.ese;
					s_d.rsp_valid = 1'b1;
				end
				status_pkg::CMD_ESR_RD:
				begin
					s_d.rsp_data = s_q.esr;
					s_d.rsp_valid = 1'b1;
					s_d.esr = status_pkg::ESR_RESET;
				end
				status_pkg::CMD_STB_RD:
				begin
					s_d.rsp_data = stb;
					s_d.rsp_data[status_pkg::STB_REQ_FLAG] = summary_flag;
					s_d.rsp_valid = 1'b1;
				end
				status_pkg::CMD_CLS:
				begin
					s_d.esr = status_pkg::ESR_RESET;
					s_d.opc_armed = 1'b0;
					s_d.clear_status = 1'b1;
				end
				status_pkg::CMD_OPC:
				begin
					s_d.opc_armed = 1'b1;
				end
			endcase
		end

		// events arriving with a read or clear are kept
		s_d.esr = s_d.esr | esr_set;
		s_d.esr[status_pkg::ESR_RQC] = 1'b0;

		// preset beats events in the same cycle; it never sets the
		// power-on bit, only reset release does
		if (preset)
		begin
			s_d.sre = status_pkg::SRE_RESET;
			s_d.ese = status_pkg::ESE_RESET;
			s_d.esr = status_pkg::ESR_RESET;
			s_d.opc_armed = 1'b0;
		end

		// line pulled low while a request is pending
		s_d.srq_o = 1'b0;
		s_d.srq_oe = s_d.req_flag;
	end

	// synchronous reset; boot stays set so that the first edge after
	// release latches the power-on event
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.sre <= status_pkg::SRE_RESET;
			s_q.ese <= status_pkg::ESE_RESET;
			s_q.esr <= status_pkg::ESR_RESET;
			s_q.boot <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// every output is a flip-flop of the state record
	assign rsp_data = s_q.rsp_data;
	assign rsp_valid = s_q.rsp_valid;
	assign poll_data = s_q.poll_data;
	assign poll_valid = s_q.poll_valid;
	assign srq_o = s_q.srq_o;
	assign srq_oe = s_q.srq_oe;
	assign clear_status = s_q.clear_status;

endmodule

`default_nettype wire

/* verification/ssr_asserts.sv */
// port assertions for the status and service request block
// assumes a bind from the bench top; one clock domain
`timescale 1ns/100ps
`default_nettype none

module ssr_asserts
(
	// clock, reset and commands
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic preset,
	input wire logic cmd_valid,
	input wire status_pkg::cmd_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_valid,
	// poll and request line
	input wire logic [7:0] poll_data,
	input wire logic poll_valid,
	input wire logic srq_o,
	input wire logic srq_oe,
	input wire logic clear_status
);
	logic [7:0] sre_q;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// shadow mask; preset beats a write in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || preset)
			sre_q <= 8'h00;
		else if (cmd_valid && cmd_op == status_pkg::CMD_SRE_WR)
			sre_q <= cmd_data;
	end
	sequence rd_cmd;
		cmd_valid && cmd_op inside {status_pkg::CMD_SRE_RD,
			status_pkg::CMD_ESE_RD, status_pkg::CMD_ESR_RD,
			status_pkg::CMD_STB_RD};
	endsequence
	sequence answer_of(op);
		rsp_valid && $past(cmd_op) == op;
	endsequence
	a_answer_next: assert property (rd_cmd |=> rsp_valid)
		else $error("query not answered");
	a_stb_summary: assert property (answer_of(status_pkg::CMD_STB_RD)
		|-> rsp_data[6] == |(rsp_data & $past(sre_q) & 8'hBF))
		else $error("status byte summary wrong");
	a_sre_echo: assert property (answer_of(status_pkg::CMD_SRE_RD)
		|-> rsp_data == $past(sre_q))
		else $error("mask readback wrong");
	a_esr_bit1: assert property (answer_of(status_pkg::CMD_ESR_RD)
		|-> !rsp_data[1])
		else $error("event bit 1 set");
	a_poll_flag: assert property (poll_valid |-> poll_data[6] == $past(srq_oe))
		else $error("poll flag wrong");
	a_fall_poll: assert property ($fell(srq_oe) |-> poll_valid)
		else $error("request dropped without poll");
	a_srq_low: assert property (srq_o == 1'b0)
		else $error("request line driven high");
	a_cls_pulse: assert property (clear_status
		|-> $past(cmd_valid && cmd_op == status_pkg::CMD_CLS))
		else $error("clear pulse without command");
endmodule

`default_nettype wire

/* verification/poll_ctrl.sv */
// bus controller model: serial-polls once the request line is low
// assumes srq_n is the resolved open-drain line with its pull-up
`timescale 1ns/100ps
`default_nettype none

module poll_ctrl
(
	// clock, line and reaction delay
	input wire logic sys_clk,
	input wire logic srq_n,
	input wire logic [3:0] lag,
	// device answer
	input wire logic poll_valid,
	input wire logic [7:0] poll_data,
	// poll pin and result
	output logic poll_strobe,
	output logic [7:0] polled,
	output logic polled_ok
);
	logic [3:0] wait_q = 4'h0;
	initial poll_strobe = 1'b0;
	// strobe is held until the byte comes back
	always @(posedge sys_clk)
	begin
		polled_ok <= poll_valid;
		wait_q <= srq_n ? 4'h0 : (wait_q == lag ? wait_q : wait_q + 4'h1);
		if (poll_valid)
		begin
			polled <= poll_data;
			poll_strobe <= 1'b0;
		end
		else if (!srq_n && wait_q == lag)
			poll_strobe <= 1'b1;
	end
endmodule

`default_nettype wire

/* verification/test_status_service_request.sv */
// self-checking bench for the status and service request block
// assumes poll_ctrl on the request line and the bound checker
`timescale 1ns/100ps
`default_nettype none

module test_status_service_request;
	logic sys_clk = 1'b0, rst_n = 1'b0, preset = 1'b0, cmd_valid = 1'b0;
	status_pkg::cmd_t cmd_op = status_pkg::CMD_SRE_RD;
	logic [7:0] cmd_data = 8'h00, rsp_data, poll_data, polled;
	logic rsp_valid, poll_valid, srq_o, srq_oe, clear_status, polled_ok;
	logic err_valid = 1'b0, ops_idle = 1'b1, oper_summary = 1'b0;
	logic ques_summary = 1'b0, err_avail = 1'b0, msg_avail = 1'b0;
	logic local_key = 1'b0, poll_strobe;
	logic signed [15:0] err_code = 16'sh0000, code;
	logic signed [15:0] corner [11] = '{-16'sd499, -16'sd400, -16'sd399,
		-16'sd300, 16'sd1, 16'sd32767, -16'sd299, -16'sd200, -16'sd199,
		-16'sd100, -16'sd500};
	logic [3:0] lag = 4'h2;
	logic [31:0] seed = 32'h08AA;
	int err_count = 0, compares = 0, cycles = 0;
	status_service_request dut_u (.sys_clk, .rst_n, .preset, .cmd_valid,
		.cmd_op, .cmd_data, .rsp_data, .rsp_valid, .err_valid, .err_code,
		.ops_idle, .oper_summary, .ques_summary, .err_avail, .msg_avail,
		.local_key, .poll_strobe, .poll_data, .poll_valid, .srq_o, .srq_oe,
		.clear_status);
	poll_ctrl host_u (.sys_clk, .srq_n(!(srq_oe && !srq_o)), .lag,
		.poll_valid, .poll_data, .poll_strobe, .polled, .polled_ok);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] esr_of(input logic signed [15:0] c);
		return (c >= -16'sd499 && c <= -16'sd400) ? 8'h04 :
			(c >= -16'sd399 && c <= -16'sd300 || c > 0) ? 8'h08 :
			(c >= -16'sd299 && c <= -16'sd200) ? 8'h10 :
			(c >= -16'sd199 && c <= -16'sd100) ? 8'h20 : 8'h00;
	endfunction
	// bit 6 of a query answer is the enabled summary, mask bit 6 ignored
	function automatic logic [7:0] stb_of(input logic [7:0] b, sre);
		return b | {1'b0, |(b & sre & 8'hBF), 6'h00};
	endfunction
	task automatic print_verdict();
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input status_pkg::cmd_t op, input logic [7:0] d);
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
	endtask
	task automatic rd(input status_pkg::cmd_t op, input logic [7:0] exp);
		cmd(op, 8'h00);
		chk(rsp_data, exp);
	endtask
	task automatic err(input logic signed [15:0] c);
		@(negedge sys_clk);
		err_valid = 1'b1;
		err_code = c;
		@(negedge sys_clk);
		err_valid = 1'b0;
	endtask
	task automatic wait_poll(input logic [7:0] exp);
		for (int n = 0; n < 100 && polled_ok !== 1'b1; n++)
			@(negedge sys_clk);
		chk(polled, exp);
		chk({7'h00, srq_oe}, 8'h00);
	endtask
	initial
	begin
		forever #2 sys_clk = !sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(status_pkg::CMD_ESR_RD, 8'h80);
		rd(status_pkg::CMD_ESR_RD, 8'h00);
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			code = i < 11 ? corner[i] : -$signed({7'h00, seed[8:0]});
			err(code);
			rd(status_pkg::CMD_ESR_RD, esr_of(code));
		end
		local_key = 1'b1;
		repeat (4) @(negedge sys_clk);
		local_key = 1'b0;
		rd(status_pkg::CMD_ESR_RD, 8'h40);
		ops_idle = 1'b0;
		cmd(status_pkg::CMD_OPC, 8'h00);
		rd(status_pkg::CMD_ESR_RD, 8'h00);
		ops_idle = 1'b1;
		rd(status_pkg::CMD_ESR_RD, 8'h01);
		cmd(status_pkg::CMD_SRE_WR, seed[7:0] | 8'h40);
		rd(status_pkg::CMD_SRE_RD, seed[7:0] | 8'h40);
		cmd(status_pkg::CMD_ESE_WR, seed[15:8]);
		rd(status_pkg::CMD_ESE_RD, seed[15:8]);
		preset = 1'b1;
		@(negedge sys_clk);
		preset = 1'b0;
		rd(status_pkg::CMD_SRE_RD, 8'h00);
		rd(status_pkg::CMD_ESE_RD, 8'h00);
		// masks before events, so no stray request
		cmd(status_pkg::CMD_ESE_WR, 8'h20);
		cmd(status_pkg::CMD_SRE_WR, 8'h60);
		err(-16'sd150);
		wait_poll(8'h60);
		rd(status_pkg::CMD_STB_RD, 8'h60);
		lag = 4'hF;
		cmd(status_pkg::CMD_SRE_WR, 8'hD0);
		oper_summary = 1'b1;
		repeat (2) @(negedge sys_clk);
		msg_avail = 1'b1;
		wait_poll(8'hF0);
		ques_summary = 1'b1;
		err_avail = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk({7'h00, srq_oe}, 8'h00);
		rd(status_pkg::CMD_STB_RD, stb_of(8'hBC, 8'hD0));
		cmd(status_pkg::CMD_CLS, 8'h00);
		rd(status_pkg::CMD_ESR_RD, 8'h00);
		rd(status_pkg::CMD_STB_RD, stb_of(8'h9C, 8'hD0));
		print_verdict();
	end
endmodule

bind status_service_request ssr_asserts chk_u (.sys_clk(sys_clk),
	.rst_n(rst_n), .preset(preset), .cmd_valid(cmd_valid),
	.cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_data(rsp_data),
	.rsp_valid(rsp_valid), .poll_data(poll_data),
	.poll_valid(poll_valid), .srq_o(srq_o), .srq_oe(srq_oe),
	.clear_status(clear_status));

`default_nettype wire
